// file: core/relay_control_register_map.sv
// Relay control register bank for module zero of a six-position switch card
// Functional notes
// - Six 1 kB module windows from the card base
// - Only lower 512 bytes decode relay registers
// - Only module zero has relay registers
// - Address is card base plus window plus offset
// - Bit one closes relay, zero opens it
// - Whole 16-bit word replaces sixteen relays at once
// - Offset zero: bit 0 first, bit 15 sixteenth
// - Offsets 2 and 4 hold relays 17-48
// - Option nibbles at offsets 6 and 8
// - Each slot owns eight consecutive relays
// - Option lines reported as sensed levels
// - Relay write starts busy, one microsecond per count
`timescale 1ns/10ps
`default_nettype none

module relay_control_register_map
  import relay_map_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Host bus request and card base
  input wire bus_req_t bus_req_in,
  input wire logic [ADDR_W-1:0] card_base_in,
  // Settle delay count in microseconds
  input wire logic [DATA_W-1:0] settle_delay_in,
  // Option identification lines, four per slot
  input wire logic [SLOT_COUNT*OPT_W-1:0] option_code_in,
  // Host bus answer
  output bus_rsp_t bus_rsp_out,
  // Relay coil commands, bit 0 is the first relay
  output logic [RELAY_COUNT-1:0] relay_drive_out,
  // Settle busy indication
  output logic busy_out
);

  // Select decode shared by write and read paths
  function automatic logic [SEL_W-1:0] reg_sel(input logic [9:0] ofs);
    logic [SEL_W-1:0] s;
    s = '0;
    s[SEL_LOW] = (ofs[9:1] == OFS_RELAY_LOW[9:1]);
    s[SEL_MID] = (ofs[9:1] == OFS_RELAY_MID[9:1]);
    s[SEL_HIGH] = (ofs[9:1] == OFS_RELAY_HIGH[9:1]);
    s[SEL_OPT_A] = (ofs[9:1] == OFS_OPTION_A[9:1]);
    s[SEL_OPT_B] = (ofs[9:1] == OFS_OPTION_B[9:1]);
    return s;
  endfunction

  logic [ADDR_W-1:0] card_ofs;
  logic in_card;
  logic in_relay_half;
  logic [2:0] module_idx;
  logic area_hit;
  logic [SEL_W-1:0] sel;
  logic wr_en;
  logic rd_en;
  logic relay_wr;
  logic [7:0] slot_relay_r [SLOT_COUNT];
  logic [DATA_W-1:0] read_word;
  bus_rsp_t rsp_r;
  busy_state_t busy_state_r;
  busy_state_t busy_state_nxt;
  logic [15:0] us_left_r;
  logic [5:0] prescale_r;

  // Offset into the card, then window and half decode
  assign card_ofs = bus_req_in.addr - card_base_in;
  assign in_card = (card_ofs < CARD_SPAN);
  assign module_idx = card_ofs[12:10];
  assign in_relay_half = (card_ofs[9:0] < RELAY_AREA[9:0]);
  assign area_hit = in_card && in_relay_half;
  assign sel = (module_idx == MODULE_IMPLEMENTED) ? reg_sel(card_ofs[9:0]) : '0;
  assign wr_en = bus_req_in.wr && area_hit;
  assign rd_en = bus_req_in.rd && area_hit;
  assign relay_wr = wr_en && (sel[SEL_HIGH:SEL_LOW] != 3'h0);

  // Per-slot relay bytes; a bank write loads both of its slots together
  generate
    for (genvar s = 0; s < SLOT_COUNT; s++) begin : g_slot
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          slot_relay_r[s] <= SLOT_RELAY_RESET;
        end else if (wr_en && sel[s/2]) begin
          slot_relay_r[s] <= bus_req_in.wdata[(s%2)*RELAYS_PER_SLOT +: RELAYS_PER_SLOT];
        end
      end
      assign relay_drive_out[s*RELAYS_PER_SLOT +: RELAYS_PER_SLOT] = slot_relay_r[s];
    end
  endgenerate

  // Read data mux: relay banks and sensed option levels
  always_comb begin
    read_word = RDATA_RESET;
    if (sel[SEL_LOW]) begin
      read_word = {slot_relay_r[1], slot_relay_r[0]};
    end
    if (sel[SEL_MID]) begin
      read_word = {slot_relay_r[3], slot_relay_r[2]};
    end
    if (sel[SEL_HIGH]) begin
      read_word = {slot_relay_r[5], slot_relay_r[4]};
    end
    if (sel[SEL_OPT_A]) begin
      read_word = option_code_in[4*OPT_W-1:0];
    end
    if (sel[SEL_OPT_B]) begin
      read_word = {8'h00, option_code_in[SLOT_COUNT*OPT_W-1:4*OPT_W]};
    end
  end

  // Answer register: ack one cycle after any access in a relay area
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_r.ack <= 1'b0;
      rsp_r.rdata <= RDATA_RESET;
    end else begin
      rsp_r.ack <= wr_en || rd_en;
      rsp_r.rdata <= rd_en ? read_word : RDATA_RESET;
    end
  end
  assign bus_rsp_out = rsp_r;

  // Settle timer next state; a new relay write restarts the count
  always_comb begin
    busy_state_nxt = busy_state_r;
    unique case (busy_state_r)
      BUSY_IDLE: begin
        if (relay_wr && settle_delay_in != 16'h0000) begin
          busy_state_nxt = BUSY_TIMING;
        end
      end
      BUSY_TIMING: begin
        if (relay_wr) begin
          busy_state_nxt = (settle_delay_in != 16'h0000) ? BUSY_TIMING : BUSY_IDLE;
        end else if (prescale_r == PRESCALE_LAST && us_left_r == 16'h0001) begin
          busy_state_nxt = BUSY_IDLE;
        end
      end
      default: busy_state_nxt = BUSY_IDLE;
    endcase
  end

  // Settle timer state
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_state_r <= BUSY_IDLE;
    end else begin
      busy_state_r <= busy_state_nxt;
    end
  end

  // Microsecond prescaler and remaining count
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prescale_r <= PRESCALE_RESET;
      us_left_r <= US_LEFT_RESET;
    end else if (relay_wr) begin
      prescale_r <= PRESCALE_RESET;
      us_left_r <= settle_delay_in;
    end else if (busy_state_r == BUSY_TIMING) begin
      if (prescale_r == PRESCALE_LAST) begin
        prescale_r <= PRESCALE_RESET;
        us_left_r <= us_left_r - 16'h0001;
      end else begin
        prescale_r <= prescale_r + 6'h01;
      end
    end
  end
  assign busy_out = busy_state_r[1];

  // Checking helpers: busy length against the loaded count
  logic [21:0] busy_len_r;
  logic [21:0] busy_exp_r;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_len_r <= 22'h000000;
      busy_exp_r <= 22'h000000;
    end else if (relay_wr) begin
      busy_len_r <= 22'h000000;
      busy_exp_r <= 22'(settle_delay_in * CYC_PER_US);
    end else if (busy_out) begin
      busy_len_r <= busy_len_r + 22'h000001;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_write_low;
    wr_en && sel[SEL_LOW];
  endsequence

  sequence s_write_mid;
    wr_en && sel[SEL_MID];
  endsequence

  sequence s_write_high;
    wr_en && sel[SEL_HIGH];
  endsequence

  sequence s_read_only(int unsigned idx);
    rd_en && !wr_en && sel[idx];
  endsequence

  a_low_bank_load: assert property (s_write_low |=> relay_drive_out[15:0] == $past(bus_req_in.wdata))
    else $error("Low relay bank did not take the written word");

  a_mid_bank_load: assert property (s_write_mid |=>
      relay_drive_out[31:16] == $past(bus_req_in.wdata) && $stable(relay_drive_out[15:0]))
    else $error("Middle relay bank load wrong or disturbed low bank");

  a_high_bank_load: assert property (s_write_high |=>
      relay_drive_out[47:32] == $past(bus_req_in.wdata) && $stable(relay_drive_out[31:0]))
    else $error("High relay bank load wrong or disturbed lower banks");

  a_relay_readback: assert property (s_read_only(SEL_MID) |=>
      bus_rsp_out.ack && bus_rsp_out.rdata == relay_drive_out[31:16])
    else $error("Relay readback does not match driven relays");

  a_option_a_read: assert property (s_read_only(SEL_OPT_A) |=>
      bus_rsp_out.rdata == $past(option_code_in[15:0]))
    else $error("Option code word A does not show sensed levels");

  a_option_b_read: assert property (s_read_only(SEL_OPT_B) |=>
      bus_rsp_out.rdata == {8'h00, $past(option_code_in[23:16])})
    else $error("Option code word B wrong or upper byte not zero");

  a_empty_modules: assert property (bus_req_in.wr && in_card && module_idx != MODULE_IMPLEMENTED |=>
      $stable(relay_drive_out))
    else $error("Write to an empty module window changed relays");

  a_upper_half_quiet: assert property ((bus_req_in.wr || bus_req_in.rd) && !area_hit |=>
      !bus_rsp_out.ack && $stable(relay_drive_out))
    else $error("Access outside relay areas was answered or took effect");

  a_busy_start: assert property (relay_wr && settle_delay_in != 16'h0000 |=>
      busy_out [*8])
    else $error("Busy did not start or dropped early after relay write");

  a_busy_length: assert property ($fell(busy_out) |-> $past(busy_len_r) + 22'h000001 == busy_exp_r)
    else $error("Busy length differs from delay count times one microsecond");

endmodule // relay_control_register_map

`default_nettype wire

// file: common/relay_map_pkg.sv
// Constants, carrier types and state codes for the relay control register map
package relay_map_pkg;

  // Bus widths
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;

  // Card address layout: six module windows, 1 kB apart, relay area in lower half
  localparam logic [31:0] MODULE_SPAN = 32'h0000_0400;
  localparam int unsigned MODULE_COUNT = 6;
  localparam logic [31:0] CARD_SPAN = 32'h0000_1800;
  localparam logic [31:0] RELAY_AREA = 32'h0000_0200;
  localparam logic [2:0] MODULE_IMPLEMENTED = 3'h0;

  // Register offsets inside the relay area of module zero
  localparam logic [9:0] OFS_RELAY_LOW = 10'h000;
  localparam logic [9:0] OFS_RELAY_MID = 10'h002;
  localparam logic [9:0] OFS_RELAY_HIGH = 10'h004;
  localparam logic [9:0] OFS_OPTION_A = 10'h006;
  localparam logic [9:0] OFS_OPTION_B = 10'h008;

  // One-hot register select positions
  localparam int unsigned SEL_LOW = 0;
  localparam int unsigned SEL_MID = 1;
  localparam int unsigned SEL_HIGH = 2;
  localparam int unsigned SEL_OPT_A = 3;
  localparam int unsigned SEL_OPT_B = 4;
  localparam int unsigned SEL_W = 5;

  // Slot and relay geometry
  localparam int unsigned SLOT_COUNT = 6;
  localparam int unsigned RELAYS_PER_SLOT = 8;
  localparam int unsigned OPT_W = 4;
  localparam int unsigned RELAY_COUNT = 48;

  // Reset values
  localparam logic [7:0] SLOT_RELAY_RESET = 8'h00;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  localparam logic [15:0] US_LEFT_RESET = 16'h0000;
  localparam logic [5:0] PRESCALE_RESET = 6'h00;

  // Settle timing: one microsecond per delay count
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SETTLE_UNIT_NS = 1000;
  localparam int unsigned CYC_PER_US = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] PRESCALE_LAST = 6'(CYC_PER_US - 1);

  // Host request and device answer
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } bus_rsp_t;

  // Settle timer states
  typedef enum logic [1:0] {
    BUSY_IDLE = 2'b01,
    BUSY_TIMING = 2'b10
  } busy_state_t;

endpackage

// file: bench/host_bus_model.sv
// Host controller model issuing single-cycle bus accesses
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
  import relay_map_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Request to the card
  output var bus_req_t bus_req_out
);
  // Idle bus at time zero
  initial bus_req_out = '0;
  // One access, held for one cycle, then released with scrambled lines
  task automatic access(input logic is_wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    bus_req_out <= '{wr: is_wr, rd: !is_wr, addr: addr, wdata: d};
    @(posedge clk_in);
    bus_req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~d};
  endtask
endmodule // host_bus_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the relay control register map
`timescale 1ns/10ps
`default_nettype none
module tb;
  import relay_map_pkg::*;
  localparam logic [31:0] BASE = 32'h00A0_0000;
  logic clk_in;
  logic rst_b_in;
  bus_req_t bus_req;
  bus_rsp_t bus_rsp;
  logic [DATA_W-1:0] settle_delay;
  logic [SLOT_COUNT*OPT_W-1:0] option_code;
  logic [RELAY_COUNT-1:0] relay_drive;
  logic busy;
  logic [DATA_W-1:0] exp_q[$];
  logic [RELAY_COUNT-1:0] relays;
  logic [DATA_W-1:0] w;
  int n_errors = 0;
  int total_checks = 0;

  // Device and host
  relay_control_register_map u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_req_in(bus_req),
    .card_base_in(BASE), .settle_delay_in(settle_delay), .option_code_in(option_code),
    .bus_rsp_out(bus_rsp), .relay_drive_out(relay_drive), .busy_out(busy));
  host_bus_model u_host (.clk_in(clk_in), .bus_req_out(bus_req));

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Compare and count
  task automatic chk(input string name, input logic [RELAY_COUNT-1:0] e, input logic [RELAY_COUNT-1:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  // Access with noted answer; refused accesses note nothing
  task automatic acc(input logic is_wr, input logic [31:0] ofs, input logic [15:0] d, input logic acked);
    if (acked) exp_q.push_back(is_wr ? 16'h0000 : d);
    u_host.access(is_wr, BASE + ofs, d);
  endtask

  // Answer watcher takes the oldest note
  always @(posedge clk_in) begin
    if (bus_rsp.ack === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected ack", 48'h0, 48'h1);
      else chk("rdata", 48'(exp_q.pop_front()), 48'(bus_rsp.rdata));
    end
  end

  // Verdict
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  // Tests
  initial begin
    void'($urandom(32'hF02707B1));
    rst_b_in = 1'b0;
    settle_delay = 16'h0000;
    option_code = 24'h000000;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    #1;
    chk("reset relays", 48'h0, relay_drive);
    chk("reset busy", 48'h0, 48'(busy));
    $display("test reset done");
    acc(1'b1, 32'h0, 16'hFFFE, 1'b1);
    #1 chk("bank low", 48'h0000_0000_FFFE, relay_drive);
    acc(1'b1, 32'h4, 16'h8001, 1'b1);
    #1 chk("bank high", 48'h8001_0000_FFFE, relay_drive);
    w = 16'($urandom);
    acc(1'b1, 32'h2, w, 1'b1);
    relays = {16'h8001, w, 16'hFFFE};
    #1 chk("bank mid", relays, relay_drive);
    acc(1'b0, 32'h0, 16'hFFFE, 1'b1);
    acc(1'b0, 32'h2, w, 1'b1);
    acc(1'b0, 32'h4, 16'h8001, 1'b1);
    $display("test banks done");
    @(posedge clk_in) option_code <= 24'($urandom);
    acc(1'b1, 32'h6, 16'hFFFF, 1'b1);
    acc(1'b0, 32'h6, option_code[15:0], 1'b1);
    acc(1'b0, 32'h8, {8'h00, option_code[23:16]}, 1'b1);
    $display("test options done");
    for (int m = 1; m < 6; m++) begin
      acc(1'b1, 32'(m) * 32'h400, 16'h0000, 1'b1);
      acc(1'b0, 32'(m) * 32'h400 + 32'h4, 16'h0000, 1'b1);
      acc(1'b1, 32'(m) * 32'h400 + 32'h200, 16'h0000, 1'b0);
    end
    acc(1'b1, 32'h200, 16'h0000, 1'b0);
    acc(1'b0, 32'h204, 16'h0000, 1'b0);
    acc(1'b1, 32'h1800, 16'h0000, 1'b0);
    acc(1'b1, 32'hFFFF_FFFE, 16'h0000, 1'b0);
    #1 chk("relays kept", relays, relay_drive);
    $display("test decode done");
    @(posedge clk_in) settle_delay <= 16'h0002;
    acc(1'b1, 32'h0, 16'h0001, 1'b1);
    relays = {16'h8001, w, 16'h0001};
    #1 chk("busy start", 48'h1, 48'(busy));
    chk("relay one", relays, relay_drive);
    repeat (79) @(posedge clk_in);
    #1 chk("busy held", 48'h1, 48'(busy));
    @(posedge clk_in);
    #1 chk("busy end", 48'h0, 48'(busy));
    // Second write during busy restarts the count with the new delay
    acc(1'b1, 32'h4, 16'h8001, 1'b1);
    repeat (20) @(posedge clk_in);
    settle_delay <= 16'h0001;
    acc(1'b1, 32'h4, 16'h8001, 1'b1);
    repeat (39) @(posedge clk_in);
    #1 chk("busy restart held", 48'h1, 48'(busy));
    @(posedge clk_in);
    #1 chk("busy restart end", 48'h0, 48'(busy));
    chk("relays after restart", relays, relay_drive);
    $display("test busy done");
    repeat (3) @(posedge clk_in);
    chk("missing acks", 48'h0, 48'(exp_q.size()));
    end_sim();
  end
endmodule // tb
`default_nettype wire
